// *** hw/cotd_core.sv ***
/*
  cotd_core: executes the tail of the instruction set (sign/zero test,
  index to accumulator copy, low-power idle) and the bit-test branch,
  with AHB-Lite access to the core registers and a small data memory.
  Assumes a single 25 MHz clock, asynchronous active-low reset and an
  interrupt request pin from outside the clock domain.
*/
// Chosen here: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module cotd_core (
  input wire logic mclk_in, // core clock, 25 MHz
  input wire logic resetn_in, // asynchronous reset, active low
  input wire logic hsel_in, // ahb slave select
  input wire logic [31:0] haddr_in, // ahb address
  input wire logic [1:0] htrans_in, // ahb transfer type
  input wire logic hwrite_in, // ahb write
  input wire logic [2:0] hsize_in, // ahb size, word only
  input wire logic [31:0] hwdata_in, // ahb write data
  input wire logic hready_in, // ahb bus ready
  output logic [31:0] hrdata_out, // ahb read data
  output logic hreadyout_out, // ahb slave ready
  output logic hresp_out, // ahb response, always okay
  input wire logic irq_req_in, // interrupt request pin
  output logic core_clk_en_out, // core clock enable, low while halted
  output logic irq_take_out // pulse: wake into interrupt service
);
  cotd_dec_if bus ();
  cotd_pkg::cotd_state_t state_q;
  logic [7:0] waddr_q, op_q, b1_q, b2_q, acc_q, idx_q, tsz_val, mem_rd;
  logic [31:0] hrdata_q;
  logic [4:0] flags_q;
  logic [15:0] pc_q, ea_q, pc_d;
  logic [3:0] cnt_q;
  logic [0:0] ctrl_q;
  logic [cotd_pkg::MEM_AW-1:0] maddr_q;
  logic [7:0] mem_q [0:(1<<cotd_pkg::MEM_AW)-1];
  logic wr_pend_q, irq_meta_q, irq_sync_q, clk_en_q, irq_take_q;
  logic aphase, launch, finish, wake, btb_taken;

  // ------------------------------------------------------------------
  // decoder and address unit
  // ------------------------------------------------------------------
  assign bus.opcode = op_q;
  assign bus.opd_hi = b1_q;
  assign bus.opd_lo = b2_q;
  assign bus.index = idx_q;
  assign bus.pc = pc_q;

  cotd_decode u_dec (
    .bus (bus)
  );

  cotd_ea u_ea (
    .bus (bus)
  );

  // ------------------------------------------------------------------
  // ahb-lite slave: zero wait states, okay always
  // ------------------------------------------------------------------
  assign aphase = hsel_in && htrans_in[1] && hready_in;
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign hrdata_out = hrdata_q;

  // capture the write address for the data phase
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_pend_q <= 1'b0;
      waddr_q <= 8'h00;
    end else begin
      wr_pend_q <= aphase && hwrite_in && (haddr_in[31:8] == 24'h000000);
      waddr_q <= haddr_in[7:0];
    end
  end

  // read data registered in the address phase; unmapped reads zero
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      hrdata_q <= 32'h00000000;
    end else if (aphase && !hwrite_in) begin
      hrdata_q <= 32'h00000000;
      if (haddr_in[31:8] == 24'h000000) begin
        unique case (haddr_in[7:0])
          cotd_pkg::REG_INSTR: hrdata_q <= {8'h00, b2_q, b1_q, op_q};
          cotd_pkg::REG_ACC: hrdata_q <= {24'h000000, acc_q};
          cotd_pkg::REG_INDEX: hrdata_q <= {24'h000000, idx_q};
          cotd_pkg::REG_FLAGS: hrdata_q <= {27'h0000000, flags_q};
          cotd_pkg::REG_PC: hrdata_q <= {16'h0000, pc_q};
          cotd_pkg::REG_STATUS: hrdata_q <= {ea_q, 13'h0000, irq_sync_q,
                                             state_q == cotd_pkg::ST_HALT, state_q == cotd_pkg::ST_EXEC};
          cotd_pkg::REG_CTRL: hrdata_q <= {31'h00000000, ctrl_q};
          cotd_pkg::REG_MADDR: hrdata_q <= {{(32 - cotd_pkg::MEM_AW){1'b0}}, maddr_q};
          cotd_pkg::REG_MDATA: hrdata_q <= {24'h000000, mem_rd};
          default: hrdata_q <= 32'h00000000;
        endcase
      end
    end
  end

  // ------------------------------------------------------------------
  // interrupt request synchroniser
  // ------------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_meta_q <= 1'b0;
      irq_sync_q <= 1'b0;
    end else begin
      irq_meta_q <= irq_req_in;
      irq_sync_q <= irq_meta_q;
    end
  end

  // ------------------------------------------------------------------
  // sequencing
  // ------------------------------------------------------------------
  assign launch = wr_pend_q && (waddr_q == cotd_pkg::REG_INSTR) && (state_q == cotd_pkg::ST_IDLE);
  assign finish = (state_q == cotd_pkg::ST_EXEC) && ((cnt_q + 4'h1) == bus.cycles);
  assign wake = (state_q == cotd_pkg::ST_HALT) && irq_sync_q && ctrl_q[cotd_pkg::CTRL_IRQEN];

  // state and cycle counter
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= cotd_pkg::ST_IDLE;
      cnt_q <= 4'h0;
    end else begin
      unique case (state_q)
        cotd_pkg::ST_IDLE: begin
          cnt_q <= 4'h0;
          if (launch) begin
            state_q <= cotd_pkg::ST_EXEC;
          end
        end
        cotd_pkg::ST_EXEC: begin
          cnt_q <= cnt_q + 4'h1;
          if (finish) begin
            state_q <= bus.is_wait ? cotd_pkg::ST_HALT : cotd_pkg::ST_IDLE;
          end
        end
        cotd_pkg::ST_HALT: begin
          if (wake) begin
            state_q <= cotd_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // instruction latch: writes while busy are ignored
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      op_q <= 8'h00;
      b1_q <= 8'h00;
      b2_q <= 8'h00;
    end else if (launch) begin
      op_q <= hwdata_in[7:0];
      b1_q <= hwdata_in[15:8];
      b2_q <= hwdata_in[23:16];
    end
  end

  // ------------------------------------------------------------------
  // operands and next pc
  // ------------------------------------------------------------------
  assign mem_rd = mem_q[maddr_q];

  always_comb begin
    if (op_q[7:4] == cotd_pkg::HI_INHA) begin
      tsz_val = acc_q;
    end else if (op_q[7:4] == cotd_pkg::HI_INHX) begin
      tsz_val = idx_q;
    end else begin
      tsz_val = mem_q[bus.ea[cotd_pkg::MEM_AW-1:0]];
    end
    btb_taken = mem_q[bus.ea[cotd_pkg::MEM_AW-1:0]][op_q[3:1]] ^ op_q[0];
    if (bus.is_btb && btb_taken) begin
      pc_d = bus.br_target;
    end else begin
      pc_d = pc_q + {14'h0000, bus.nbytes};
    end
  end

  // ------------------------------------------------------------------
  // architectural registers
  // ------------------------------------------------------------------
  // accumulator: hardware copy wins over a software write
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      acc_q <= 8'h00;
    end else if (finish && bus.is_copy) begin
      acc_q <= idx_q;
    end else if (wr_pend_q && waddr_q == cotd_pkg::REG_ACC) begin
      acc_q <= hwdata_in[7:0];
    end
  end

  // index register, software only
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      idx_q <= 8'h00;
    end else if (wr_pend_q && waddr_q == cotd_pkg::REG_INDEX) begin
      idx_q <= hwdata_in[7:0];
    end
  end

  // condition flags: hardware updates win over software writes
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      flags_q <= cotd_pkg::RST_FLAGS;
    end else if (finish && bus.is_tsz) begin
      flags_q[cotd_pkg::FLG_N] <= tsz_val[7];
      flags_q[cotd_pkg::FLG_Z] <= (tsz_val == 8'h00);
    end else if (finish && bus.is_wait) begin
      flags_q[cotd_pkg::FLG_I] <= 1'b0;
    end else if (wake) begin
      flags_q[cotd_pkg::FLG_I] <= 1'b1;
    end else if (wr_pend_q && waddr_q == cotd_pkg::REG_FLAGS) begin
      flags_q <= hwdata_in[cotd_pkg::FLG_W-1:0];
    end
  end

  // program counter and last effective address
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pc_q <= cotd_pkg::RST_PC;
      ea_q <= 16'h0000;
    end else if (finish) begin
      pc_q <= pc_d;
      ea_q <= bus.ea;
    end else if (wr_pend_q && waddr_q == cotd_pkg::REG_PC) begin
      pc_q <= hwdata_in[15:0];
    end
  end

  // control and memory pointer
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_q <= 1'b0;
      maddr_q <= '0;
    end else begin
      if (wr_pend_q && waddr_q == cotd_pkg::REG_CTRL) begin
        ctrl_q <= hwdata_in[cotd_pkg::CTRL_IRQEN];
      end
      if (wr_pend_q && waddr_q == cotd_pkg::REG_MADDR) begin
        maddr_q <= hwdata_in[cotd_pkg::MEM_AW-1:0];
      end
    end
  end

  // data memory, written only by software
  always_ff @(posedge mclk_in) begin
    if (wr_pend_q && waddr_q == cotd_pkg::REG_MDATA) begin
      mem_q[maddr_q] <= hwdata_in[7:0];
    end
  end

  // ------------------------------------------------------------------
  // clock gate and wake pulse
  // ------------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      clk_en_q <= 1'b1;
      irq_take_q <= 1'b0;
    end else begin
      irq_take_q <= wake;
      if (finish && bus.is_wait) begin
        clk_en_q <= 1'b0;
      end else if (wake) begin
        clk_en_q <= 1'b1;
      end
    end
  end

  assign core_clk_en_out = clk_en_q;
  assign irq_take_out = irq_take_q;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);

  sequence copy_start_s;
    launch && (hwdata_in[7:0] == cotd_pkg::OP_COPY);
  endsequence
  sequence wait_start_s;
    launch && (hwdata_in[7:0] == cotd_pkg::OP_WAIT);
  endsequence
  sequence exec_two_s;
    (state_q == cotd_pkg::ST_EXEC)[*2] ##1 (state_q != cotd_pkg::ST_EXEC);
  endsequence

  test_flags_a: assert property (finish && bus.is_tsz |=> flags_q[cotd_pkg::FLG_N] == $past(tsz_val[7])
    && flags_q[cotd_pkg::FLG_Z] == ($past(tsz_val) == 8'h00) && $stable(flags_q[cotd_pkg::FLG_C])
    && $stable(flags_q[cotd_pkg::FLG_H]) && $stable(flags_q[cotd_pkg::FLG_I]) && $stable(acc_q))
    else $error("test instruction altered the wrong state");
  copy_index_a: assert property (finish && bus.is_copy |=> acc_q == $past(idx_q) && $stable(flags_q))
    else $error("index copy wrong or flags changed");
  copy_cycles_a: assert property (copy_start_s |=> exec_two_s)
    else $error("index copy did not take two cycles");
  wait_cycles_a: assert property (wait_start_s |=> exec_two_s ##0 (state_q == cotd_pkg::ST_HALT
    && !core_clk_en_out && !flags_q[cotd_pkg::FLG_I]))
    else $error("idle instruction did not halt with mask clear");
  mode_map_a: assert property ((op_q[7:4] == cotd_pkg::HI_IDX0 |-> bus.mode == cotd_pkg::AM_IDX0)
    and (op_q[7:4] == cotd_pkg::HI_IDXB |-> bus.mode == cotd_pkg::AM_IDXB)
    and (op_q[7:4] == cotd_pkg::HI_LIT |-> bus.mode == cotd_pkg::AM_LIT))
    else $error("high nibble decoded to wrong mode");
  word_offset_a: assert property (bus.mode == cotd_pkg::AM_IDXW |-> bus.ea == {b1_q, b2_q} + {8'h00, idx_q})
    else $error("word offset address wrong");
  byte_offset_a: assert property (bus.mode == cotd_pkg::AM_IDXB |-> bus.ea == {8'h00, b1_q} + {8'h00, idx_q})
    else $error("byte offset address wrong");
  full_addr_a: assert property (bus.mode == cotd_pkg::AM_FULL |-> bus.ea == {b1_q, b2_q})
    else $error("full address wrong");
  bit_branch_a: assert property (finish && bus.is_btb |=> pc_q == ($past(btb_taken) ?
    $past(pc_q) + cotd_pkg::BTB_LEN + {{8{$past(b2_q[7])}}, $past(b2_q)} : $past(pc_q) + cotd_pkg::BTB_LEN))
    else $error("bit branch target wrong");
  wake_run_a: assert property (wake |=> core_clk_en_out && irq_take_out && flags_q[cotd_pkg::FLG_I]
    ##1 !irq_take_out)
    else $error("enabled interrupt did not restart the core");
endmodule // cotd_core

// *** common/cotd_pkg.sv ***
/*
  cotd_pkg: shared constants of the opcode decode tail (register map,
  flag positions, opcode fields, addressing modes, cycle counts).
  Assumes one 25 MHz core clock and a 32-bit AHB-Lite register bus.
*/
package cotd_pkg;
  // ------------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ------------------------------------------------------------------
  localparam logic [7:0] REG_INSTR = 8'h00;
  localparam logic [7:0] REG_ACC = 8'h04;
  localparam logic [7:0] REG_INDEX = 8'h08;
  localparam logic [7:0] REG_FLAGS = 8'h0c;
  localparam logic [7:0] REG_PC = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_CTRL = 8'h18;
  localparam logic [7:0] REG_MADDR = 8'h1c;
  localparam logic [7:0] REG_MDATA = 8'h20;
  // ------------------------------------------------------------------
  // flag bits, control bits, reset values
  // ------------------------------------------------------------------
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_I = 3;
  localparam int FLG_H = 4;
  localparam int FLG_W = 5;
  localparam int CTRL_IRQEN = 0;
  localparam logic [4:0] RST_FLAGS = 5'h08;
  localparam logic [15:0] RST_PC = 16'h0000;
  localparam int MEM_AW = 6;
  // ------------------------------------------------------------------
  // opcode fields: high nibble is the mode, low nibble the operation
  // ------------------------------------------------------------------
  localparam logic [7:0] OP_COPY = 8'h9f;
  localparam logic [7:0] OP_WAIT = 8'h8f;
  localparam logic [3:0] LO_TSZ = 4'hd;
  localparam logic [3:0] HI_BTB = 4'h0;
  localparam logic [3:0] HI_BSET = 4'h1;
  localparam logic [3:0] HI_REL = 4'h2;
  localparam logic [3:0] HI_DIR = 4'h3;
  localparam logic [3:0] HI_INHA = 4'h4;
  localparam logic [3:0] HI_INHX = 4'h5;
  localparam logic [3:0] HI_IX1R = 4'h6;
  localparam logic [3:0] HI_IXR = 4'h7;
  localparam logic [3:0] HI_CTL8 = 4'h8;
  localparam logic [3:0] HI_CTL9 = 4'h9;
  localparam logic [3:0] HI_LIT = 4'ha;
  localparam logic [3:0] HI_DIRM = 4'hb;
  localparam logic [3:0] HI_FULL = 4'hc;
  localparam logic [3:0] HI_IDXW = 4'hd;
  localparam logic [3:0] HI_IDXB = 4'he;
  localparam logic [3:0] HI_IDX0 = 4'hf;
  typedef enum logic [2:0] {AM_INH, AM_LIT, AM_DIR, AM_FULL, AM_IDX0, AM_IDXB, AM_IDXW, AM_BTB} cotd_mode_t;
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_HALT} cotd_state_t;
  // ------------------------------------------------------------------
  // cycle counts, instruction lengths, pc steps
  // ------------------------------------------------------------------
  localparam logic [3:0] CYC_TSZ_DIR = 4'h4;
  localparam logic [3:0] CYC_TSZ_INH = 4'h3;
  localparam logic [3:0] CYC_TSZ_IDXB = 4'h5;
  localparam logic [3:0] CYC_TSZ_IDX0 = 4'h4;
  localparam logic [3:0] CYC_COPY = 4'h2;
  localparam logic [3:0] CYC_WAIT = 4'h2;
  localparam logic [3:0] CYC_OTHER = 4'h2;
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;
  localparam logic [15:0] PC_STEP = 16'h0001;
  localparam logic [15:0] BTB_LEN = 16'h0003;
endpackage

// *** common/cotd_dec_if.sv ***
/*
  cotd_dec_if: carries the latched instruction to the decoder and the
  address unit and their results back to the core.
  Assumes all parties sit in the core clock domain.
*/
`timescale 1ns/1ps
interface cotd_dec_if;
  logic [7:0] opcode;
  logic [7:0] opd_hi;
  logic [7:0] opd_lo;
  logic [7:0] index;
  logic [15:0] pc;
  cotd_pkg::cotd_mode_t mode;
  logic [3:0] op;
  logic is_tsz;
  logic is_copy;
  logic is_wait;
  logic is_btb;
  logic [3:0] cycles;
  logic [1:0] nbytes;
  logic [15:0] ea;
  logic [15:0] br_target;
  modport core (output opcode, opd_hi, opd_lo, index, pc,
                input mode, op, is_tsz, is_copy, is_wait, is_btb, cycles, nbytes, ea, br_target);
  modport dec (input opcode, output mode, op, is_tsz, is_copy, is_wait, is_btb, cycles, nbytes);
  modport eau (input mode, opd_hi, opd_lo, index, pc, output ea, br_target);
endinterface

// *** hw/cotd_decode.sv ***
/*
  cotd_decode: purely combinational opcode decoder.
  Assumes the opcode on the interface is held stable by the core.
*/
`timescale 1ns/1ps
module cotd_decode (
  cotd_dec_if.dec bus // decode side of the instruction interface
);
  logic [3:0] hi;
  logic [3:0] lo;

  // ------------------------------------------------------------------
  // mode, length, class and cycle count
  // ------------------------------------------------------------------
  // nibble split decode
  always_comb begin
    hi = bus.opcode[7:4];
    lo = bus.opcode[3:0];
    bus.op = lo;
    bus.is_tsz = (lo == cotd_pkg::LO_TSZ) && (hi >= cotd_pkg::HI_DIR) && (hi <= cotd_pkg::HI_IXR);
    bus.is_copy = (bus.opcode == cotd_pkg::OP_COPY);
    bus.is_wait = (bus.opcode == cotd_pkg::OP_WAIT);
    bus.is_btb = (hi == cotd_pkg::HI_BTB);
    unique case (hi)
      cotd_pkg::HI_BTB: begin
        bus.mode = cotd_pkg::AM_BTB;
        bus.nbytes = cotd_pkg::LEN_THREE;
      end
      cotd_pkg::HI_BSET, cotd_pkg::HI_DIR, cotd_pkg::HI_DIRM: begin
        bus.mode = cotd_pkg::AM_DIR;
        bus.nbytes = cotd_pkg::LEN_TWO;
      end
      cotd_pkg::HI_REL, cotd_pkg::HI_LIT: begin
        bus.mode = cotd_pkg::AM_LIT;
        bus.nbytes = cotd_pkg::LEN_TWO;
      end
      cotd_pkg::HI_INHA, cotd_pkg::HI_INHX, cotd_pkg::HI_CTL8, cotd_pkg::HI_CTL9: begin
        bus.mode = cotd_pkg::AM_INH;
        bus.nbytes = cotd_pkg::LEN_ONE;
      end
      cotd_pkg::HI_IX1R, cotd_pkg::HI_IDXB: begin
        bus.mode = cotd_pkg::AM_IDXB;
        bus.nbytes = cotd_pkg::LEN_TWO;
      end
      cotd_pkg::HI_IXR, cotd_pkg::HI_IDX0: begin
        bus.mode = cotd_pkg::AM_IDX0;
        bus.nbytes = cotd_pkg::LEN_ONE;
      end
      cotd_pkg::HI_FULL: begin
        bus.mode = cotd_pkg::AM_FULL;
        bus.nbytes = cotd_pkg::LEN_THREE;
      end
      cotd_pkg::HI_IDXW: begin
        bus.mode = cotd_pkg::AM_IDXW;
        bus.nbytes = cotd_pkg::LEN_THREE;
      end
    endcase
    // cycle count of the instructions this block executes
    if (bus.is_tsz) begin
      unique case (bus.mode)
        cotd_pkg::AM_DIR: bus.cycles = cotd_pkg::CYC_TSZ_DIR;
        cotd_pkg::AM_IDXB: bus.cycles = cotd_pkg::CYC_TSZ_IDXB;
        cotd_pkg::AM_IDX0: bus.cycles = cotd_pkg::CYC_TSZ_IDX0;
        default: bus.cycles = cotd_pkg::CYC_TSZ_INH;
      endcase
    end else if (bus.is_copy) begin
      bus.cycles = cotd_pkg::CYC_COPY;
    end else if (bus.is_wait) begin
      bus.cycles = cotd_pkg::CYC_WAIT;
    end else begin
      bus.cycles = cotd_pkg::CYC_OTHER;
    end
  end
endmodule // cotd_decode

// *** hw/cotd_ea.sv ***
/*
  cotd_ea: effective address and bit-branch target calculation.
  Assumes operand bytes are in fetch order: opd_hi first, opd_lo second.
*/
`timescale 1ns/1ps
module cotd_ea (
  cotd_dec_if.eau bus // address side of the instruction interface
);
  // ------------------------------------------------------------------
  // effective address per addressing mode
  // ------------------------------------------------------------------
  always_comb begin
    unique case (bus.mode)
      cotd_pkg::AM_DIR, cotd_pkg::AM_BTB: bus.ea = {8'h00, bus.opd_hi};
      cotd_pkg::AM_FULL: bus.ea = {bus.opd_hi, bus.opd_lo};
      cotd_pkg::AM_IDX0: bus.ea = {8'h00, bus.index};
      cotd_pkg::AM_IDXB: bus.ea = {8'h00, bus.index} + {8'h00, bus.opd_hi};
      cotd_pkg::AM_IDXW: bus.ea = {bus.opd_hi, bus.opd_lo} + {8'h00, bus.index};
      cotd_pkg::AM_INH, cotd_pkg::AM_LIT: bus.ea = bus.pc + cotd_pkg::PC_STEP;
    endcase
  end

  assign bus.br_target = bus.pc + cotd_pkg::BTB_LEN + {{8{bus.opd_lo[7]}}, bus.opd_lo};
endmodule // cotd_ea

// *** dv/cpu_opcode_decode_tail_tb.sv ***
/*
  cpu_opcode_decode_tail_tb: self-checking bench for cotd_core over AHB-Lite.
  Assumes hready is looped back from hreadyout and one 25 MHz clock.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_fail++; $display("MISMATCH %0t got %h exp %h", $time, a, e); end end
module cpu_opcode_decode_tail_tb;
  logic mclk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic irq_req = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] r;
  logic hrdy, hresp, clk_en, take;
  int n_fail = 0;
  int compares = 0;
  // clock, 40 ns period
  always #20 mclk_in = ~mclk_in;
  cotd_core u_dut (.mclk_in(mclk_in), .resetn_in(resetn_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hrdy),
    .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp), .irq_req_in(irq_req),
    .core_clk_en_out(clk_en), .irq_take_out(take));
  // --------------------------------------------------------------
  // bus and execution helpers
  // --------------------------------------------------------------
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge mclk_in); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk_in); while (hrdy !== 1'b1);
    r = hrdata;
  endtask
  // start an instruction, expect busy one cycle before its end, idle after
  task automatic run(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2, input int n);
    bus(1'b1, cotd_pkg::REG_INSTR, {8'h0, b2, b1, op});
    repeat (n - 1) @(posedge mclk_in);
    bus(1'b0, cotd_pkg::REG_STATUS, 32'h0);
    `CHK(r[0], 1'b1)
    bus(1'b0, cotd_pkg::REG_STATUS, 32'h0);
    `CHK(r[0], 1'b0)
  endtask
  task automatic test_done;
    if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_test;
    logic [7:0] ops[5] = '{8'h3d, 8'h4d, 8'h5d, 8'h6d, 8'h7d};
    int cyc[5] = '{4, 3, 3, 5, 4};
    bus(1'b1, cotd_pkg::REG_ACC, 32'h0);
    bus(1'b1, cotd_pkg::REG_INDEX, 32'h0);
    bus(1'b1, cotd_pkg::REG_MADDR, 32'h0);
    bus(1'b1, cotd_pkg::REG_MDATA, 32'h0);
    bus(1'b1, cotd_pkg::REG_MADDR, 32'h5);
    bus(1'b1, cotd_pkg::REG_MDATA, 32'h0);
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, cotd_pkg::REG_FLAGS, 32'h1d);
      run(ops[i], 8'h05, 8'h00, cyc[i]);
      bus(1'b0, cotd_pkg::REG_FLAGS, 32'h0);
      `CHK(r[4:0], 5'h1b)
    end
    bus(1'b1, cotd_pkg::REG_ACC, 32'h80);
    run(8'h4d, 8'h00, 8'h00, 3);
    bus(1'b0, cotd_pkg::REG_FLAGS, 32'h0);
    `CHK(r[4:0], 5'h1d)
    bus(1'b0, cotd_pkg::REG_ACC, 32'h0);
    `CHK(r[7:0], 8'h80)
  endtask
  task automatic t_copy;
    bus(1'b1, cotd_pkg::REG_INDEX, 32'ha5);
    bus(1'b1, cotd_pkg::REG_FLAGS, 32'h17);
    run(cotd_pkg::OP_COPY, 8'h00, 8'h00, 2);
    bus(1'b0, cotd_pkg::REG_ACC, 32'h0);
    `CHK(r[7:0], 8'ha5)
    bus(1'b0, cotd_pkg::REG_FLAGS, 32'h0);
    `CHK(r[4:0], 5'h17)
  endtask
  task automatic t_modes;
    logic [7:0] ops[5] = '{8'ha6, 8'he6, 8'hd6, 8'hc6, 8'hf6};
    logic [15:0] ea[5] = '{16'h0201, 16'h0110, 16'h1324, 16'h1234, 16'h00f0};
    bus(1'b1, cotd_pkg::REG_INDEX, 32'hf0);
    bus(1'b1, cotd_pkg::REG_PC, 32'h200);
    for (int i = 0; i < 5; i++) begin
      run(ops[i], (i == 1) ? 8'h20 : 8'h12, 8'h34, 2);
      bus(1'b0, cotd_pkg::REG_STATUS, 32'h0);
      `CHK(r[31:16], ea[i])
    end
  endtask
  task automatic t_branch;
    bus(1'b1, cotd_pkg::REG_PC, 32'h100);
    run(8'h01, 8'h05, 8'h10, 2);
    bus(1'b0, cotd_pkg::REG_PC, 32'h0);
    `CHK(r[15:0], 16'h0113)
    run(8'h00, 8'h05, 8'h10, 2);
    bus(1'b0, cotd_pkg::REG_PC, 32'h0);
    `CHK(r[15:0], 16'h0116)
  endtask
  task automatic t_wait;
    bus(1'b1, cotd_pkg::REG_CTRL, 32'h1);
    run(cotd_pkg::OP_WAIT, 8'h00, 8'h00, 2);
    `CHK(clk_en, 1'b0)
    bus(1'b0, cotd_pkg::REG_FLAGS, 32'h0);
    `CHK(r[3], 1'b0)
    irq_req <= 1'b1;
    for (int i = 0; i < 8 && take !== 1'b1; i++) @(negedge mclk_in);
    `CHK(take, 1'b1)
    `CHK(clk_en, 1'b1)
    @(negedge mclk_in);
    `CHK(take, 1'b0)
    @(posedge mclk_in);
    irq_req <= 1'b0;
    bus(1'b0, cotd_pkg::REG_FLAGS, 32'h0);
    `CHK(r[3], 1'b1)
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge mclk_in);
    resetn_in <= 1'b1;
    @(posedge mclk_in);
    bus(1'b0, 8'hfc, 32'h0);
    `CHK(r, 32'h0)
    `CHK(hresp, 1'b0)
    `CHK(hrdy, 1'b1)
    t_test();
    t_copy();
    t_modes();
    t_branch();
    t_wait();
    test_done();
  end
  // watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge mclk_in);
    n_fail++;
    test_done();
  end
endmodule // cpu_opcode_decode_tail_tb
